// ### rtl/ldk_pkg.sv
// Purpose: Constants for the segment display drive and key-scan slice controller.
// Assumes: Classic Wishbone, 32-bit data, byte addresses on a 16-bit address bus.
// Notes: Register data sits in the low byte; the bits above read as zero.
package ldk_pkg;
	localparam logic [15:0] ADDR_DRIVE_MODE = 16'hffb0;
	localparam logic [15:0] ADDR_DISP_MODE = 16'hffb4;
	localparam logic [15:0] ADDR_PIN_USE = 16'hffb8;
	localparam logic [15:0] ADDR_KEY_DATA = 16'hffbc;
	localparam logic [7:0] DRIVE_MODE_RESET = 8'h00;
	localparam logic [2:0] DISP_MODE_RESET = 3'h0;
	localparam logic [1:0] PIN_USE_RESET = 2'h0;
	localparam int BIT_KEYSCAN_EN = 0;
	localparam int BIT_SCAN_PHASE = 1;
	localparam int BIT_GEN_SEL_LO = 4;
	localparam int BIT_GEN_SEL_HI = 5;
	localparam int BIT_PIN_SEG_LOW = 0;
	localparam int BIT_PIN_COM_HIGH = 1;
	localparam logic [1:0] GEN_EXTERNAL = 2'h0;
	localparam logic [1:0] GEN_INTERNAL = 2'h1;
	localparam logic [1:0] GEN_STEP_DOWN = 2'h3;
	localparam logic [2:0] MODE_SLICE8 = 3'h7;
	localparam logic [2:0] MODE_SLICE4 = 3'h0;
	localparam logic [2:0] MODE_SLICE3_THIRD = 3'h1;
	localparam logic [2:0] MODE_SLICE2 = 3'h2;
	localparam logic [2:0] MODE_SLICE3_HALF = 3'h3;
	localparam logic [2:0] MODE_STATIC = 3'h4;
	localparam int SEG_COUNT = 32;
	localparam int SCAN_SEG_FIRST = 24;
	localparam int SCAN_LINES = 8;
	localparam int SLICE_CYCLES_DEFAULT = 16;
endpackage : ldk_pkg

// ### rtl/ldk_ctrl.sv
// Purpose: Slice sequencer, pin mapping and registers of the segment display driver.
// Assumes: Slice timing comes from a divider on clk_i; display data is muxed elsewhere.
// Notes: Configuration changes reach the generator, commons and segment outputs a clock after the write; slicing follows at the next boundary.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
module ldk_ctrl #(
	parameter int SLICE_CYCLES = ldk_pkg::SLICE_CYCLES_DEFAULT
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic [ldk_pkg::SCAN_LINES-1:0] key_return_inputs_i,
	output logic [7:0] backplane_active_o,
	output logic [7:0] backplane_display_o,
	output logic [ldk_pkg::SEG_COUNT-1:0] segment_display_o,
	output logic [ldk_pkg::SCAN_LINES-1:0] scan_source_lines_o,
	output logic scan_phase_flag_o,
	output logic [3:0] slice_o,
	output logic internal_divider_o,
	output logic step_down_o
);
	import ldk_pkg::*;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [1:0] gen_sel;
		logic keyscan_enable;
		logic scan_phase;
		logic [2:0] disp_mode;
		logic [1:0] pin_use;
		logic [15:0] div_cnt;
		logic [3:0] slice;
		logic [7:0] com_active;
		logic [7:0] com_display;
		logic [SEG_COUNT-1:0] seg_display;
		logic [SCAN_LINES-1:0] scan_src;
		logic [SCAN_LINES-1:0] kr_meta;
		logic [SCAN_LINES-1:0] kr_sync;
		logic [SCAN_LINES-1:0] key_data;
		logic int_div;
		logic step_down;
	} ldk_state_s;

	ldk_state_s r;
	ldk_state_s next_r;

	localparam logic [15:0] SLICE_LAST = 16'(SLICE_CYCLES - 1);

	// Number of display slices for a mode code; prohibited codes fall back to static.
	// mode code decode
	function automatic logic [3:0] slice_count(input logic [2:0] mode);
		logic [3:0] n;
		n = 4'h1;
		case (mode)
			MODE_SLICE8: begin
				n = 4'h8;
			end
			MODE_SLICE4: begin
				n = 4'h4;
			end
			MODE_SLICE3_THIRD: begin
				n = 4'h3;
			end
			MODE_SLICE2: begin
				n = 4'h2;
			end
			MODE_SLICE3_HALF: begin
				n = 4'h3;
			end
			MODE_STATIC: begin
				n = 4'h1;
			end
			default: begin
				n = 4'h1;
			end
		endcase
		return n;
	endfunction : slice_count

	// Mask of backplane lines used by a mode.
	// commons per mode
	function automatic logic [7:0] com_mask(input logic [2:0] mode);
		logic [8:0] m;
		m = (9'h001 << slice_count(mode)) - 9'h001;
		return m[7:0];
	endfunction : com_mask

	function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] reg_addr);
		return a[15:2] == reg_addr[15:2];
	endfunction : addr_hit

	logic bus_req;
	logic tick;
	logic [3:0] n_disp;
	logic scan_on;
	logic [3:0] total;
	logic [3:0] slice_nx;

	assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;
	assign tick = (r.div_cnt == SLICE_LAST);
	assign n_disp = slice_count(r.disp_mode);
	// Static mode has no spare slice for key sources, so scan runs in every mode code except static, prohibited codes included.
	// enable gates scan
	assign scan_on = r.keyscan_enable && (r.disp_mode != MODE_STATIC);
	assign total = scan_on ? (n_disp + 4'h1) : n_disp;
	assign slice_nx = (r.slice + 4'h1 >= total) ? 4'h0 : (r.slice + 4'h1);

	always_comb begin
		next_r = r;
		next_r.ack = bus_req;
		// Key return pins cross into this clock domain through two stages.
		// only return pins sampled
		next_r.kr_meta = key_return_inputs_i;
		next_r.kr_sync = r.kr_meta;
		next_r.div_cnt = tick ? 16'h0000 : (r.div_cnt + 16'h0001);

		if (bus_req && wb_we_i && wb_sel_i[0]) begin
			if (addr_hit(wb_adr_i, ADDR_DRIVE_MODE)) begin
				// Bit one is never taken from the bus; unused bits are simply not stored.
				// flag not writable
				next_r.gen_sel = wb_dat_i[BIT_GEN_SEL_HI:BIT_GEN_SEL_LO];
				next_r.keyscan_enable = wb_dat_i[BIT_KEYSCAN_EN];
			end
			if (addr_hit(wb_adr_i, ADDR_DISP_MODE)) begin
				next_r.disp_mode = wb_dat_i[2:0];
			end
			if (addr_hit(wb_adr_i, ADDR_PIN_USE)) begin
				next_r.pin_use = wb_dat_i[1:0];
			end
		end

		next_r.dat = 32'h0000_0000;
		if (bus_req && !wb_we_i) begin
			if (addr_hit(wb_adr_i, ADDR_DRIVE_MODE)) begin
				next_r.dat[BIT_GEN_SEL_HI:BIT_GEN_SEL_LO] = r.gen_sel;
				next_r.dat[BIT_SCAN_PHASE] = r.scan_phase;
				next_r.dat[BIT_KEYSCAN_EN] = r.keyscan_enable;
			end
			if (addr_hit(wb_adr_i, ADDR_DISP_MODE)) begin
				next_r.dat[2:0] = r.disp_mode;
			end
			if (addr_hit(wb_adr_i, ADDR_PIN_USE)) begin
				next_r.dat[1:0] = r.pin_use;
			end
			if (addr_hit(wb_adr_i, ADDR_KEY_DATA)) begin
				next_r.dat[SCAN_LINES-1:0] = r.key_data;
			end
		end

		// The prohibited code 10 is treated like 00 so the resistors stay off.
		// generator decode
		next_r.int_div = (r.gen_sel == GEN_INTERNAL) || (r.gen_sel == GEN_STEP_DOWN);
		next_r.step_down = (r.gen_sel == GEN_STEP_DOWN);

		next_r.com_display = com_mask(r.disp_mode);
		if (!r.pin_use[BIT_PIN_COM_HIGH] || r.disp_mode != MODE_SLICE8) begin
			next_r.com_display[7:4] = 4'h0;
		end
		next_r.seg_display = {SEG_COUNT{1'b1}};
		if (!r.pin_use[BIT_PIN_SEG_LOW]) begin
			next_r.seg_display[3:0] = 4'h0;
		end
		if (r.disp_mode == MODE_SLICE8) begin
			next_r.seg_display[SEG_COUNT-1:SEG_COUNT-4] = 4'h0;
		end

		if (tick) begin
			next_r.slice = slice_nx;
			next_r.scan_phase = scan_on && (slice_nx == n_disp);
			next_r.com_active = 8'h00;
			if (!(scan_on && slice_nx == n_disp)) begin
				next_r.com_active = 8'h01 << slice_nx[2:0];
			end
			// sources on segments 24 to 31
			next_r.scan_src = (scan_on && slice_nx == n_disp) ? {SCAN_LINES{1'b1}} : '0;
			// Returns are captured at the end of the key slice, once lines have settled.
			if (r.scan_phase) begin
				next_r.key_data = r.kr_sync;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.gen_sel <= DRIVE_MODE_RESET[BIT_GEN_SEL_HI:BIT_GEN_SEL_LO];
			r.keyscan_enable <= DRIVE_MODE_RESET[BIT_KEYSCAN_EN];
			r.disp_mode <= DISP_MODE_RESET;
			r.pin_use <= PIN_USE_RESET;
			r.com_active <= 8'h01;
		end else begin
			r <= next_r;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign backplane_active_o = r.com_active;
	assign backplane_display_o = r.com_display;
	assign segment_display_o = r.seg_display;
	assign scan_source_lines_o = r.scan_src;
	assign scan_phase_flag_o = r.scan_phase;
	assign slice_o = r.slice;
	assign internal_divider_o = r.int_div;
	assign step_down_o = r.step_down;

	property p_scan_src;
		@(posedge clk_i) disable iff (rst_i)
		scan_phase_flag_o |-> (scan_source_lines_o == 8'hff) && (backplane_active_o == 8'h00);
	endproperty
	a_scan_src: assert property (p_scan_src) else $error("key slice without sources");

	property p_disp_src;
		@(posedge clk_i) disable iff (rst_i)
		!scan_phase_flag_o |-> (scan_source_lines_o == 8'h00);
	endproperty
	a_disp_src: assert property (p_disp_src) else $error("sources during display");

	property p_scan_off;
		@(posedge clk_i) disable iff (rst_i)
		tick && !r.keyscan_enable |=> !scan_phase_flag_o;
	endproperty
	a_scan_off: assert property (p_scan_off) else $error("scan while disabled");

	property p_high_com;
		@(posedge clk_i) disable iff (rst_i)
		(backplane_display_o[7:4] != 4'h0) |-> $past(r.disp_mode) == MODE_SLICE8;
	endproperty
	a_high_com: assert property (p_high_com) else $error("high commons outside 8 slices");

	property p_seg28;
		@(posedge clk_i) disable iff (rst_i)
		$past(r.disp_mode) == MODE_SLICE8 |-> segment_display_o[31:28] == 4'h0;
	endproperty
	a_seg28: assert property (p_seg28) else $error("too many segments");

	property p_flag_tick;
		@(posedge clk_i) disable iff (rst_i)
		$changed(scan_phase_flag_o) |-> $past(tick);
	endproperty
	a_flag_tick: assert property (p_flag_tick) else $error("flag moved off boundary");

	property p_reset_clear;
		@(posedge clk_i)
		rst_i |=> (r.gen_sel == 2'h0) && !r.keyscan_enable && !r.scan_phase;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("mode not cleared");

	property p_step_down;
		@(posedge clk_i) disable iff (rst_i)
		step_down_o |-> internal_divider_o && $past(r.gen_sel) == GEN_STEP_DOWN;
	endproperty
	a_step_down: assert property (p_step_down) else $error("bad generator decode");

	property p_com_used;
		@(posedge clk_i) disable iff (rst_i)
		$rose(tick) ##1 !scan_phase_flag_o |-> backplane_active_o[slice_o[2:0]];
	endproperty
	a_com_used: assert property (p_com_used) else $error("wrong common active");

	property p_scan_last;
		@(posedge clk_i) disable iff (rst_i)
		$fell(scan_phase_flag_o) |-> slice_o == 4'h0;
	endproperty
	a_scan_last: assert property (p_scan_last) else $error("key slice not last");

	property p_key_capture;
		@(posedge clk_i) disable iff (rst_i)
		$changed(r.key_data) |-> $past(r.scan_phase) && $past(tick);
	endproperty
	a_key_capture: assert property (p_key_capture) else $error("returns taken off slice");

	property p_extra_slice;
		@(posedge clk_i) disable iff (rst_i)
		$rose(scan_phase_flag_o) |-> slice_o == slice_count($past(r.disp_mode));
	endproperty
	a_extra_slice: assert property (p_extra_slice) else $error("key slice misplaced");

	property p_seg_low;
		@(posedge clk_i) disable iff (rst_i)
		!$past(r.pin_use[0]) |-> segment_display_o[3:0] == 4'h0;
	endproperty
	a_seg_low: assert property (p_seg_low) else $error("shared segments driven");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

	property p_reset_out;
		@(posedge clk_i)
		rst_i |=> !wb_ack_o && (wb_dat_o == 32'h0000_0000) && (slice_o == 4'h0)
			&& (backplane_active_o == 8'h01) && !scan_phase_flag_o;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");

	property p_gen_apply;
		@(posedge clk_i) disable iff (rst_i)
		bus_req && wb_we_i && wb_sel_i[0] && addr_hit(wb_adr_i, ADDR_DRIVE_MODE) |=> ##1
			(internal_divider_o == $past(wb_dat_i[BIT_GEN_SEL_LO], 2))
			&& (step_down_o == ($past(wb_dat_i[BIT_GEN_SEL_HI:BIT_GEN_SEL_LO], 2) == GEN_STEP_DOWN));
	endproperty
	a_gen_apply: assert property (p_gen_apply) else $error("generator select not applied");

	property p_flag_read;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i[15:2]) == ADDR_DRIVE_MODE[15:2])
			|-> wb_dat_o[BIT_SCAN_PHASE] == $past(scan_phase_flag_o);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag bit reads wrong");

	property p_unused_zero;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i[15:2]) == ADDR_DRIVE_MODE[15:2])
			|-> (wb_dat_o[31:6] == 26'h0) && (wb_dat_o[3:2] == 2'h0);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused mode bits set");

	property p_static_noscan;
		@(posedge clk_i) disable iff (rst_i)
		tick && (r.disp_mode == MODE_STATIC) |=> !scan_phase_flag_o;
	endproperty
	a_static_noscan: assert property (p_static_noscan) else $error("key slice in static");

	property p_slice_hold;
		@(posedge clk_i) disable iff (rst_i)
		!tick |=> $stable(slice_o);
	endproperty
	a_slice_hold: assert property (p_slice_hold) else $error("slice moved off boundary");

	property p_seg_upper;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && (r.disp_mode != MODE_SLICE8) |=> segment_display_o[SEG_COUNT-1:SEG_COUNT-4] == 4'hf;
	endproperty
	a_seg_upper: assert property (p_seg_upper) else $error("upper segments off");

	property p_com_high_on;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && (r.disp_mode == MODE_SLICE8) && r.pin_use[BIT_PIN_COM_HIGH]
			|=> backplane_display_o[7:4] == 4'hf;
	endproperty
	a_com_high_on: assert property (p_com_high_on) else $error("high commons missing");
endmodule : ldk_ctrl

// ### tb/ldk_keypad.sv
// Purpose: Key matrix model on the key return inputs of the display driver.
// Assumes: A pressed key joins its return line to the driven scan sources.
// Notes: Outside the key slice the returns carry junk on purpose.
`timescale 1ns/10ps
module ldk_keypad (
	input wire logic [7:0] pressed_i,
	input wire logic [7:0] src_i,
	output logic [7:0] ret_o
);
	// returns follow sources
	// Inverted data outside the key slice catches a capture taken at the wrong time.
	assign ret_o = (src_i == 8'hff) ? pressed_i : ~pressed_i;
endmodule : ldk_keypad

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the display slice and key scan controller.
// Assumes: Short slices of four clocks; keypad model on the return inputs.
// Notes: Random drive-mode bits and key patterns from a fixed seed.
`timescale 1ns/10ps
module tb_top;
	import ldk_pkg::*;
	localparam int SC = 4;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, flag, idiv, sdown;
	logic [15:0] adr = 0;
	logic [3:0] sel = 0, slice;
	logic [31:0] wdat = 0, rd, dat_o, seg, v;
	logic [7:0] ret, bp_act, bp_disp, src, keys = 0;
	logic [2:0] codes [6] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
	int slc [6] = '{8, 4, 3, 2, 3, 1};
	logic [1:0] gens [3] = '{2'h0, 2'h1, 2'h3};
	int failures = 0, total_checks = 0, cycles = 0, n;
	ldk_ctrl #(.SLICE_CYCLES(SC)) ldk_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(dat_o), .key_return_inputs_i(ret),
		.backplane_active_o(bp_act), .backplane_display_o(bp_disp),
		.segment_display_o(seg), .scan_source_lines_o(src), .scan_phase_flag_o(flag),
		.slice_o(slice), .internal_divider_o(idiv), .step_down_o(sdown));
	ldk_keypad ldk_keypad_inst (.pressed_i(keys), .src_i(src), .ret_o(ret));
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("Error timeout expected end seen hang");
			end_sim();
		end
	end
	task end_sim();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask : wb
	// Counts negedges until the next rise of the scan flag, passing any high phase first.
	task next_rise(output int c);
		c = 0;
		while (flag === 1'b1 && c < 200) begin @(negedge clk_i); c++; end
		while (flag !== 1'b1 && c < 200) begin @(negedge clk_i); c++; end
	endtask : next_rise
	function automatic logic [7:0] com_exp(input int s, input logic hi);
		if (s == 8) return hi ? 8'hff : 8'h0f;
		return 8'((1 << s) - 1);
	endfunction : com_exp
	initial begin
		n = $urandom(32'hc7ae);
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		wb(0, ADDR_DRIVE_MODE, 0, rd);
		chk("drive_mode", 32'h0, rd);
		chk("flag", 0, flag);
		chk("seg low", 32'hffff_fff0, seg);
		$display("test reset done");
		foreach (gens[i]) begin
			// Enable stays off here so the read-only flag bit is a known zero at the read.
			v = {26'h0, gens[i], 2'h0, 1'($urandom), 1'b0}; // unused bits zero
			wb(1, ADDR_DRIVE_MODE, v, rd);
			wb(0, ADDR_DRIVE_MODE, 0, rd);
			chk("drive_mode", v & 32'h31, rd);
			@(negedge clk_i);
			chk("gen", {gens[i] == 2'h3, gens[i][0]}, {sdown, idiv});
		end
		$display("test generator done");
		wb(1, ADDR_PIN_USE, 32'h3, rd);
		wb(1, ADDR_DRIVE_MODE, 32'h1, rd);
		foreach (codes[i]) begin
			wb(1, ADDR_DISP_MODE, codes[i], rd);
			repeat (2) @(negedge clk_i);
			chk("commons", com_exp(slc[i], 1), bp_disp);
			chk("seg count", slc[i] == 8 ? 28 : 32, $countones(seg));
			if (slc[i] == 1) begin
				n = 0;
				repeat (40) begin @(negedge clk_i); if (flag !== 1'b0) n++; end
				chk("static flag", 0, n);
			end else begin
				next_rise(n);
				next_rise(n);
				chk("frame", (slc[i] + 1) * SC, n);
				chk("sources", 8'hff, src);
				chk("active", 0, {bp_act, slice} ^ slc[i]);
				wb(0, ADDR_DRIVE_MODE, 0, rd);
				chk("drive_mode scan", 32'h3, rd);
				while (flag === 1'b1) @(negedge clk_i);
				chk("first com", 8'h01, bp_act);
			end
			$display("test mode %0d done", codes[i]);
		end
		wb(1, ADDR_DISP_MODE, MODE_SLICE8, rd);
		wb(1, ADDR_PIN_USE, 32'h1, rd);
		repeat (2) @(negedge clk_i);
		chk("commons pin", 8'h0f, bp_disp);
		wb(1, ADDR_DISP_MODE, MODE_SLICE4, rd);
		@(posedge clk_i);
		keys <= 8'($urandom);
		next_rise(n);
		next_rise(n);
		while (flag === 1'b1) @(negedge clk_i);
		wb(0, ADDR_KEY_DATA, 0, rd);
		chk("key data", keys, rd);
		wb(1, ADDR_DRIVE_MODE, 32'h0, rd);
		n = 0;
		repeat (60) begin @(negedge clk_i); if (flag !== 1'b0) n++; end
		chk("scan off", 0, n);
		wb(0, 16'hff00, 0, rd);
		chk("unmapped", 0, rd);
		$display("test keys done");
		end_sim();
	end
endmodule : tb_top
